// File: src/pin_mux_cfg.svh
// Offsets, reset values, field encodings and sizes for the port C/D pin-function block
`ifndef PIN_MUX_CFG_SVH
`define PIN_MUX_CFG_SVH

`define PMX_ADDR_W        12
`define PMX_OFF_PORT_C    12'h000
`define PMX_OFF_PORT_D    12'h004
`define PMX_REG_W         16
`define PMX_PIN_CNT       8
`define PMX_BE_W          2
`define PMX_RST_PORT_C    16'hf000
`define PMX_RST_PORT_D    16'hf0cc
`define PMX_D_SPECIAL_PIN 5
`define PMX_MODE_ALT      2'h0
`define PMX_MODE_OUT      2'h1
`define PMX_MODE_IN_PU    2'h2
`define PMX_MODE_IN_NOPU  2'h3
`define PMX_STRB_ALL      4'hf

`endif

// File: src/pin_mux_pkg.sv
// Types and the per-pin mode decode shared by the pin-function block
package pin_mux_pkg;
`include "pin_mux_cfg.svh"

    typedef enum logic [1:0] {
        PIN_ALT,
        PIN_OUT,
        PIN_IN_PULL_UP,
        PIN_IN_FLOAT
    } pin_mode_t;

    // Pin steering: alternate function, output drive, pull-up
    typedef struct packed {
        logic alt;
        logic out;
        logic pull;
    } pin_attr_t;

    function automatic pin_attr_t pin_attr(input logic [1:0] field, input logic special);
        pin_attr_t a;
        pin_mode_t m;
        a = '0;
        m = PIN_ALT;
        if (field == `PMX_MODE_OUT) begin
            m = PIN_OUT;
        end else if (field == `PMX_MODE_IN_PU) begin
            m = PIN_IN_PULL_UP;
        end else if (field == `PMX_MODE_IN_NOPU) begin
            m = PIN_IN_FLOAT;
        end
        case (m)
            PIN_ALT:        a.alt = 1'b1;
            // Forbidden code on the special pin: never drive, fall back to plain input
            PIN_OUT:        a.out = ~special;
            PIN_IN_PULL_UP: a.pull = 1'b1;
            default:        a = '0;
        endcase
        return a;
    endfunction : pin_attr

endpackage : pin_mux_pkg

// File: src/cfg_word_reg.sv
// One 16-bit control word with byte-lane writes and a fixed reset value
`timescale 1ns/1ps
`include "pin_mux_cfg.svh"
module cfg_word_reg #(
    parameter logic [`PMX_REG_W-1:0] RESET_VAL = '0
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_b_i,
    input  wire logic                  wr_en_i,
    input  wire logic [`PMX_BE_W-1:0]  be_i,
    input  wire logic [`PMX_REG_W-1:0] wdata_i,
    output logic      [`PMX_REG_W-1:0] q_o
);
    genvar b;
    generate
        for (b = 0; b < `PMX_BE_W; b++) begin : g_lane
            always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    q_o[8*b +: 8] <= RESET_VAL[8*b +: 8];
                end else if (wr_en_i && be_i[b]) begin
                    q_o[8*b +: 8] <= wdata_i[8*b +: 8];
                end
            end
        end
    endgenerate
endmodule : cfg_word_reg

// File: src/port_cd_pin_function_select.sv
// Pin-function select for ports C and D behind an APB slave
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "pin_mux_cfg.svh"

module port_cd_pin_function_select
    import pin_mux_pkg::*;
(
    input  wire logic                    ref_clk_i,
    input  wire logic                    rst_b_i,
    input  wire logic [`PMX_ADDR_W-1:0]  paddr_i,
    input  wire logic                    psel_i,
    input  wire logic                    penable_i,
    input  wire logic                    pwrite_i,
    input  wire logic [31:0]             pwdata_i,
    input  wire logic [3:0]              pstrb_i,
    output logic      [31:0]             prdata_o,
    output logic                         pready_o,
    output logic                         pslverr_o,
    output logic      [`PMX_PIN_CNT-1:0] port_c_alt_sel_o,
    output logic      [`PMX_PIN_CNT-1:0] port_c_out_en_o,
    output logic      [`PMX_PIN_CNT-1:0] port_c_pull_up_en_o,
    output logic      [`PMX_PIN_CNT-1:0] port_d_alt_sel_o,
    output logic      [`PMX_PIN_CNT-1:0] port_d_out_en_o,
    output logic      [`PMX_PIN_CNT-1:0] port_d_pull_up_en_o
);
    logic [`PMX_REG_W-1:0]   port_c_pin_function_control;
    logic [`PMX_REG_W-1:0]   port_d_pin_function_control;
    logic [`PMX_PIN_CNT-1:0] c_alt_d;
    logic [`PMX_PIN_CNT-1:0] c_out_d;
    logic [`PMX_PIN_CNT-1:0] c_pull_d;
    logic [`PMX_PIN_CNT-1:0] d_alt_d;
    logic [`PMX_PIN_CNT-1:0] d_out_d;
    logic [`PMX_PIN_CNT-1:0] d_pull_d;

    // Whole-word pin image; a constant here so the async reset branch loads constants only
    function automatic logic [3*`PMX_PIN_CNT-1:0] pin_image(input logic [`PMX_REG_W-1:0] w,
                                                           input logic is_d);
        pin_attr_t                 a;
        logic [3*`PMX_PIN_CNT-1:0] img;
        img = '0;
        for (int i = 0; i < `PMX_PIN_CNT; i++) begin
            a = pin_attr(w[2*i +: 2], is_d && (i == `PMX_D_SPECIAL_PIN));
            img[2*`PMX_PIN_CNT+i] = a.alt;
            img[`PMX_PIN_CNT+i]   = a.out;
            img[i]                = a.pull;
        end
        return img;
    endfunction : pin_image

    localparam logic [3*`PMX_PIN_CNT-1:0] C_RST_IMG = pin_image(`PMX_RST_PORT_C, 1'b0);
    localparam logic [3*`PMX_PIN_CNT-1:0] D_RST_IMG = pin_image(`PMX_RST_PORT_D, 1'b1);

    // Bus decode
    wire        setup_w   = psel_i && !penable_i;
    wire        sel_c_w   = (paddr_i == `PMX_OFF_PORT_C);
    wire        sel_d_w   = (paddr_i == `PMX_OFF_PORT_D);
    wire        mapped_w  = sel_c_w || sel_d_w;
    wire        access_w  = psel_i && penable_i && pready_o;
    wire        wr_c_w    = access_w && pwrite_i && sel_c_w;
    wire        wr_d_w    = access_w && pwrite_i && sel_d_w;
    wire [31:0] rd_mux_w  = sel_c_w ? {16'h0000, port_c_pin_function_control} :
                            sel_d_w ? {16'h0000, port_d_pin_function_control} : 32'h0000_0000;
    wire [`PMX_BE_W-1:0] be_w = pstrb_i[`PMX_BE_W-1:0];

    cfg_word_reg #(.RESET_VAL(`PMX_RST_PORT_C)) u_port_c_reg (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .wr_en_i   (wr_c_w),
        .be_i      (be_w),
        .wdata_i   (pwdata_i[`PMX_REG_W-1:0]),
        .q_o       (port_c_pin_function_control)
    );

    cfg_word_reg #(.RESET_VAL(`PMX_RST_PORT_D)) u_port_d_reg (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .wr_en_i   (wr_d_w),
        .be_i      (be_w),
        .wdata_i   (pwdata_i[`PMX_REG_W-1:0]),
        .q_o       (port_d_pin_function_control)
    );

    // Answer one cycle after setup: one access cycle, never stretched
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= setup_w;
            pslverr_o <= setup_w && !mapped_w;
            prdata_o  <= (setup_w && !pwrite_i) ? rd_mux_w : 32'h0000_0000;
        end
    end

    // Per-pin decode
    genvar n;
    generate
        for (n = 0; n < `PMX_PIN_CNT; n++) begin : g_pin
            localparam logic SPECIAL = (n == `PMX_D_SPECIAL_PIN);
            pin_attr_t a_c;
            pin_attr_t a_d;
            assign a_c = pin_attr(port_c_pin_function_control[2*n +: 2], 1'b0);
            assign a_d = pin_attr(port_d_pin_function_control[2*n +: 2], SPECIAL);
            assign c_alt_d[n]    = a_c.alt;
            assign c_out_d[n]    = a_c.out;
            assign c_pull_d[n]   = a_c.pull;
            assign d_alt_d[n]    = a_d.alt;
            assign d_out_d[n]    = a_d.out;
            assign d_pull_d[n]   = a_d.pull;
        end
    endgenerate

    // Registered pin controls lag the control word by one cycle
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            {port_c_alt_sel_o, port_c_out_en_o, port_c_pull_up_en_o} <= C_RST_IMG;
            {port_d_alt_sel_o, port_d_out_en_o, port_d_pull_up_en_o} <= D_RST_IMG;
        end else begin
            port_c_alt_sel_o    <= c_alt_d;
            port_c_out_en_o     <= c_out_d;
            port_c_pull_up_en_o <= c_pull_d;
            port_d_alt_sel_o    <= d_alt_d;
            port_d_out_en_o     <= d_out_d;
            port_d_pull_up_en_o <= d_pull_d;
        end
    end

    sequence full_wr_c_s;
        psel_i && penable_i && pready_o && pwrite_i && sel_c_w && pstrb_i == `PMX_STRB_ALL;
    endsequence

    sequence full_wr_d_s;
        psel_i && penable_i && pready_o && pwrite_i && sel_d_w && pstrb_i == `PMX_STRB_ALL;
    endsequence

    sequence rd_c_s;
        setup_w && !pwrite_i && sel_c_w ##1 penable_i;
    endsequence

    sequence rd_d_s;
        setup_w && !pwrite_i && sel_d_w ##1 penable_i;
    endsequence

    port_c_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        full_wr_c_s |=> port_c_pin_function_control == $past(pwdata_i[15:0]))
        else $error("port C word did not take written data");

    port_d_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        full_wr_d_s |=> port_d_pin_function_control == $past(pwdata_i[15:0]))
        else $error("port D word did not take written data");

    port_c_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        rd_c_s |-> pready_o && prdata_o == {16'h0000, port_c_pin_function_control})
        else $error("port C read data wrong");

    alt_out_map_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        port_c_pin_function_control[5:4] == `PMX_MODE_OUT
        |=> port_c_out_en_o[2] && !port_c_alt_sel_o[2] && !port_c_pull_up_en_o[2])
        else $error("code 01 did not give output drive");

    alt_sel_map_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        port_d_pin_function_control[15:14] == `PMX_MODE_ALT
        |=> port_d_alt_sel_o[7] && !port_d_out_en_o[7])
        else $error("code 00 did not select alternate function");

    pull_on_map_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        port_c_pin_function_control[13:12] == `PMX_MODE_IN_PU
        |=> port_c_pull_up_en_o[6] && !port_c_out_en_o[6] && !port_c_alt_sel_o[6])
        else $error("code 10 did not give input with pull-up");

    pull_off_map_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        port_d_pin_function_control[1:0] == `PMX_MODE_IN_NOPU
        |=> !port_d_pull_up_en_o[0] && !port_d_out_en_o[0] && !port_d_alt_sel_o[0])
        else $error("code 11 did not give floating input");

    d5_no_drive_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        port_d_pin_function_control[11:10] != `PMX_MODE_ALT
        |=> !port_d_out_en_o[5] && !port_d_alt_sel_o[5])
        else $error("port D pin 5 driven or dedicated in wrong code");

    field_pos_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        $changed(port_c_pin_function_control[7:6]) && port_c_pin_function_control[7:6] ==
        `PMX_MODE_OUT |=> port_c_out_en_o[3] ##1 port_c_out_en_o[3])
        else $error("pin 3 not steered by bits 7 and 6");

    port_d_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        rd_d_s |-> pready_o && prdata_o == {16'h0000, port_d_pin_function_control})
        else $error("port D read data wrong");

    ready_after_setup_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        setup_w |=> pready_o)
        else $error("no answer in the cycle after setup");

    ready_one_cycle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        pready_o |=> !pready_o)
        else $error("ready stood longer than one cycle");

    unmapped_err_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        setup_w && !mapped_w |=> pready_o && pslverr_o)
        else $error("unmapped address gave no error");

    mapped_no_err_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        setup_w && mapped_w |=> !pslverr_o)
        else $error("mapped address gave an error");

    idle_rdata_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        !pready_o |-> prdata_o == 32'h0000_0000)
        else $error("read data not zero outside the access cycle");

    strobe_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        wr_d_w && be_w == '0 |=> $stable(port_d_pin_function_control))
        else $error("port D word changed with no lane strobed");

    d5_dedicated_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        port_d_pin_function_control[11:10] == `PMX_MODE_ALT
        |=> port_d_alt_sel_o[5] && !port_d_out_en_o[5] && !port_d_pull_up_en_o[5])
        else $error("port D pin 5 code 00 did not select the dedicated function");

endmodule : port_cd_pin_function_select

// File: tb/port_cd_pin_function_select_tb.sv
// Self-checking bench for the port C/D pin-function select block
`timescale 1ns/1ps
`include "pin_mux_cfg.svh"
module port_cd_pin_function_select_tb;
    typedef struct {
        logic [11:0] a;
        logic [31:0] d;
        logic [3:0]  s;
        logic [15:0] e;
    } row_t;

    logic        ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0]  pstrb;
    logic [7:0]  c_alt, c_out, c_pull, d_alt, d_out, d_pull;
    int          n_fail, n_checks, cyc;
    // Every code on both ports; software never gives pin 5 of D the forbidden code
    row_t rows[6] = '{
        '{12'h000, 32'habcd_e45b, 4'hf, 16'he45b},
        '{12'h004, 32'h1234_e01b, 4'hf, 16'he01b},
        '{12'h004, 32'h0000_0800, 4'hf, 16'h0800},
        '{12'h000, 32'hffff_0000, 4'h1, 16'he400},
        '{12'h004, 32'h0000_ffff, 4'hc, 16'h0800},
        '{12'h004, 32'h0000_5100, 4'h2, 16'h5100}};

    port_cd_pin_function_select i_dut (
        .ref_clk_i(ref_clk), .rst_b_i(rst_b), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .port_c_alt_sel_o(c_alt), .port_c_out_en_o(c_out), .port_c_pull_up_en_o(c_pull),
        .port_d_alt_sel_o(d_alt), .port_d_out_en_o(d_out), .port_d_pull_up_en_o(d_pull));

    always #5 ref_clk = ~ref_clk;

    // Reference decode, kept apart from the design's own function
    function automatic logic [23:0] decode(input logic [15:0] w, input logic is_d);
        logic [7:0] a, o, p;
        logic [1:0] f;
        for (int n = 0; n < 8; n++) begin
            f = w[2*n+1 -: 2];
            a[n] = (f == 2'h0);
            o[n] = (f == 2'h1) && !(is_d && n == 5);
            p[n] = (f == 2'h2);
        end
        return {a, o, p};
    endfunction : decode

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic er);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) n_fail++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk_pins(input logic [15:0] cw, input logic [15:0] dw);
        chk({8'h0, c_alt, c_out, c_pull}, {8'h0, decode(cw, 1'b0)});
        chk({8'h0, d_alt, d_out, d_pull}, {8'h0, decode(dw, 1'b1)});
    endtask : chk_pins

    task automatic chk_regs(input logic [15:0] cw, input logic [15:0] dw);
        apb(1'b0, 12'h000, 32'h0, 4'h0, r, e);
        chk(r, {16'h0, cw});
        apb(1'b0, 12'h004, 32'h0, 4'h0, r, e);
        chk(r, {16'h0, dw});
        chk_pins(cw, dw);
    endtask : chk_regs

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    // Hang guard, far above the fewer than a hundred cycles the tests need
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc >= 5000) begin
            n_fail++;
            end_of_test();
        end
    end

    initial begin
        ref_clk = 1'b0;
        rst_b = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {n_fail, n_checks, cyc} = '0;
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        chk_regs(16'hf000, 16'hf0cc);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d, rows[i].s, r, e);
            chk({31'h0, e}, 32'h0);
            apb(1'b0, rows[i].a, 32'h0, 4'h0, r, e);
            chk(r, {16'h0, rows[i].e});
            if (rows[i].a == 12'h000) begin
                chk({8'h0, c_alt, c_out, c_pull}, {8'h0, decode(rows[i].e, 1'b0)});
            end else begin
                chk({8'h0, d_alt, d_out, d_pull}, {8'h0, decode(rows[i].e, 1'b1)});
            end
        end
        // Unmapped place: error, no effect on either word
        apb(1'b1, 12'h008, 32'h0000_ffff, 4'hf, r, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 12'h008, 32'h0, 4'h0, r, e);
        chk({r[30:0], e}, 32'h1);
        chk_regs(16'he400, 16'h5100);
        // Reset in mid-run restores the reset words at once
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk_pins(16'hf000, 16'hf0cc);
        chk({30'h0, pready, pslverr}, 32'h0);
        chk(prdata, 32'h0);
        rst_b <= 1'b1;
        chk_regs(16'hf000, 16'hf0cc);
        end_of_test();
    end
endmodule : port_cd_pin_function_select_tb
